// ---- ddd_align_top.sv ----
// module: dynamic digital delay alignment controller with avalon slave
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module ddd_align_top
  import ddd_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic [AW-1:0]      address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [DW-1:0]      writedata,
  output logic      [DW-1:0]      readdata,
  output logic                    waitrequest,
  input  wire logic               align_pin,
  input  wire logic               lock_indication,
  output logic      [NUM_GRP-1:0] group_clk,
  output logic      [NUM_GRP-1:0] group_half,
  output logic                    align_busy,
  output logic                    holdover_active
);

  ddd_ctrl_s           ctrl_r;
  ddd_grp_s            grp_r [NUM_GRP];
  ddd_state_e          state_r;
  ddd_state_e          state_nxt;
  logic                wait_r;
  logic [DW-1:0]       rdata_r;
  logic [DW-1:0]       rdata_nxt;
  logic                wr_go;
  logic                wr_grp;
  logic                wr_final;
  logic [1:0]          wr_idx;
  logic                pin_s1_r;
  logic                pin_s2_r;
  logic                lvl_q_r;
  logic                lvl;
  logic                wr_req_r;
  logic                lock_s1_r;
  logic                lock_s2_r;
  logic                req_pend_r;
  logic                req_take;
  logic [1:0]          lag_cnt_r;
  logic [1:0]          pulse_cnt_r;
  logic                os_start;
  logic                qual_fall;
  logic                sel_exempt;
  logic                busy_r;
  logic                hold_r;
  logic [NUM_GRP-1:0]  fall_vec;
  logic [NUM_GRP-1:0]  pd_vec;

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then the access completes
  // ---------------------------------------------------------------
  assign wr_go    = write && !wait_r;
  assign wr_final = wr_go && address == OFS_FINAL;
  assign wr_grp   = wr_go && (address == OFS_GRP0 || address == OFS_GRP1 ||
                              address == OFS_GRP2);
  assign wr_idx   = address[3:2];

  always_comb begin
    rdata_nxt = '0;
    case (address)
      OFS_CTRL:   rdata_nxt = DW'(ctrl_r);
      OFS_STATUS: rdata_nxt = {25'h0000000, hold_r, lock_s2_r, state_r,
                               req_pend_r, busy_r};
      OFS_GRP0:   rdata_nxt = DW'(grp_r[0]);
      OFS_GRP1:   rdata_nxt = DW'(grp_r[1]);
      OFS_GRP2:   rdata_nxt = DW'(grp_r[2]);
      default:    rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else if ((read || write) && wait_r) begin
      wait_r  <= 1'b0;
      rdata_r <= rdata_nxt;
    end else begin
      wait_r  <= 1'b1;
    end
  end

  // unmapped writes and the status word are ignored; whole words only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_go && address == OFS_CTRL) begin
      ctrl_r <= ddd_ctrl_s'(writedata[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_GRP; i++) begin
        grp_r[i] <= GRP_RST;
      end
    end else if (wr_grp) begin
      grp_r[wr_idx] <= ddd_grp_s'(writedata[GRP_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // request sources
  // ---------------------------------------------------------------
  // pin into two flops; only the second is looked at
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      pin_s1_r  <= align_pin;
      pin_s2_r  <= pin_s1_r;
      lock_s1_r <= lock_indication;
      lock_s2_r <= lock_s1_r;
    end
  end

  // a polarity flip moves the level just as a pin toggle does
  assign lvl = pin_s2_r ^ ctrl_r.align_polarity_invert;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lvl_q_r  <= 1'b0;
      wr_req_r <= 1'b0;
    end else begin
      lvl_q_r  <= lvl;
      wr_req_r <= wr_final || (wr_grp && ctrl_r.align_on_write);
    end
  end

  // a new request in the cycle of the take is kept
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      req_pend_r <= 1'b0;
    end else begin
      req_pend_r <= (lvl && !lvl_q_r) || wr_req_r ||
                    (req_pend_r && !req_take);
    end
  end

  // ---------------------------------------------------------------
  // qualifying clock select
  // ---------------------------------------------------------------
  assign pd_vec = {ctrl_r.group2_powerdown, 2'b00};
  // codes past the last group never qualify and the request waits
  assign qual_fall = ctrl_r.loop_select_enable &&
                     ctrl_r.loop_select < 2'(NUM_GRP) &&
                     fall_vec[ctrl_r.loop_select];
  assign sel_exempt = ctrl_r.loop_select < 2'(NUM_GRP) &&
                      grp_r[ctrl_r.loop_select].group_align_exempt;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign req_take = state_r == ST_IDLE && req_pend_r;
  assign os_start = state_r == ST_LEAD &&
                    lag_cnt_r == ONESHOT_LAG_CYC - 2'h1;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (req_pend_r) begin
                  state_nxt = ctrl_r.align_qualify_enable ? ST_FALL1
                                                          : ST_LEAD;
                end
      ST_FALL1: if (qual_fall) begin
                  state_nxt = ST_FALL2;
                end
      ST_FALL2: if (qual_fall) begin
                  state_nxt = ST_LEAD;
                end
      ST_LEAD:  if (os_start) begin
                  state_nxt = ST_PULSE;
                end
      ST_PULSE: if (pulse_cnt_r == ONESHOT_LEN_CYC - 2'h1) begin
                  state_nxt = ST_IDLE;
                end
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lag_cnt_r   <= 2'h0;
      pulse_cnt_r <= 2'h0;
    end else begin
      lag_cnt_r   <= state_r == ST_LEAD ? lag_cnt_r + 2'h1 : 2'h0;
      pulse_cnt_r <= state_r == ST_PULSE ? pulse_cnt_r + 2'h1 : 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  // relative mode on a zero-delay loop drops lock while realigning
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      busy_r <= state_nxt != ST_IDLE;
      hold_r <= ctrl_r.zero_delay_mode && !sel_exempt && !lock_s2_r &&
                !ctrl_r.lock_loss_holdover_mask;
    end
  end

  // ---------------------------------------------------------------
  // output groups; an exempt qualifying group is left untouched in
  // absolute mode, a non-exempt one is realigned like any other
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    ddd_out_group u_grp (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .cfg         (grp_r[g]),
      .powerdown   (pd_vec[g]),
      .align_start (os_start),
      .grp_clk     (group_clk[g]),
      .grp_half    (group_half[g]),
      .fall_pulse  (fall_vec[g])
    );
  end

  assign readdata        = rdata_r;
  assign waitrequest     = wait_r;
  assign align_busy      = busy_r;
  assign holdover_active = hold_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_lead_entry;
    $rose(state_r == ST_LEAD);
  endsequence

  sequence s_pulse_run;
    (state_r == ST_PULSE)[*3] ##1 (state_r == ST_IDLE);
  endsequence

  a_bus_one_wait: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus access did not complete after one wait cycle");

  a_auto_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    wr_grp && ctrl_r.align_on_write |-> ##2 (req_pend_r || busy_r))
    else $error("group write did not raise an alignment request");

  a_final_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    wr_final |-> ##2 (req_pend_r || busy_r))
    else $error("final word write did not raise an alignment request");

  a_two_falls: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ST_FALL1 ##1 state_r == ST_FALL2 && !qual_fall
      |=> state_r == ST_FALL2)
    else $error("sequencer left before the second qualifying fall");

  a_lag_three: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_lead_entry |-> !os_start ##1 !os_start ##1 os_start ##1 s_pulse_run)
    else $error("one-shot timing is not three plus three cycles");

  a_qual_path: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ST_FALL2 && qual_fall |=> s_lead_entry)
    else $error("second qualifying fall did not start the lead");

  a_holdover_mask: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ctrl_r.lock_loss_holdover_mask |=> !holdover_active)
    else $error("holdover raised although masked");

  a_holdover_set: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ctrl_r.zero_delay_mode && !sel_exempt && !lock_s2_r &&
      !ctrl_r.lock_loss_holdover_mask |=> holdover_active)
    else $error("relative lock loss did not raise holdover");

endmodule

// ---- ddd_host_pin.sv ----
// host-side model that pulses the alignment pin high for six cycles on request
`timescale 1ns/10ps
module ddd_host_pin (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pulse_req,
  output logic      align_pin
);
  logic [3:0] hold_r;
  // ---------------------------------------------------------------
  // pin pulse
  // ---------------------------------------------------------------
  // the one-shot inside follows, so the width is loose; six cycles
  // clears the two-flop synchroniser with margin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_r    <= 4'h0;
      align_pin <= 1'b0;
    end else if (pulse_req) begin
      hold_r    <= 4'h6;
      align_pin <= 1'b1;
    end else if (hold_r != 4'h0) begin
      hold_r    <= hold_r - 4'h1;
      align_pin <= (hold_r != 4'h1);
    end
  end
endmodule

// ---- ddd_out_group.sv ----
// module: one output group divider with alignment force-low and release
`timescale 1ns/10ps
module ddd_out_group
  import ddd_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     nrst,
  input  wire ddd_grp_s cfg,
  input  wire logic     powerdown,
  input  wire logic     align_start,
  output logic          grp_clk,
  output logic          grp_half,
  output logic          fall_pulse
);

  logic [7:0]       div_cnt_r;
  logic [7:0]       div_cnt_nxt;
  logic [7:0]       high_len;
  logic             clk_r;
  logic             clk_nxt;
  logic             half_r;
  logic [7:0]       dly_act_r;
  logic             seq_act_r;
  logic [CNT_W-1:0] seq_cnt_r;
  logic [CNT_W-1:0] release_at;
  logic             take_part;

  // exempt groups never enter the sequence and keep running
  assign take_part = ~cfg.group_align_exempt & ~powerdown;
  assign high_len  = {1'b0, cfg.group_divide[7:1]} +
                     {7'h00, cfg.group_divide[0]};
  // counted from the cycle after align_start
  assign release_at = CNT_W'({7'h00, ONESHOT_LEN_CYC}) + RELEASE_BASE_CYC
                    + {1'b0, dly_act_r} - 9'h002;

  always_comb begin
    div_cnt_nxt = (div_cnt_r + 8'h01 >= cfg.group_divide) ? 8'h00
                : div_cnt_r + 8'h01;
    clk_nxt     = div_cnt_nxt < high_len;
    if (powerdown) begin
      clk_nxt = 1'b0;
    end else if (seq_act_r && seq_cnt_r == release_at) begin
      div_cnt_nxt = 8'h00;
      clk_nxt     = 1'b1;
    end else if (seq_act_r && seq_cnt_r >= FORCE_LOW_CYC - 9'h002) begin
      // a high phase cut short here shows as a glitch pulse
      div_cnt_nxt = 8'h00;
      clk_nxt     = 1'b0;
    end
  end

  assign fall_pulse = clk_r & ~clk_nxt;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= 8'h00;
      clk_r     <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      clk_r     <= clk_nxt;
    end
  end

  // ---------------------------------------------------------------
  // alignment sequence; new delay only latched by an alignment
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seq_act_r <= 1'b0;
      seq_cnt_r <= '0;
      dly_act_r <= GRP_RST.group_digital_delay;
    end else if (align_start && take_part) begin
      seq_act_r <= 1'b1;
      seq_cnt_r <= '0;
      dly_act_r <= cfg.group_digital_delay;
    end else if (seq_act_r) begin
      seq_act_r <= seq_cnt_r != release_at;
      seq_cnt_r <= seq_cnt_r + 9'h001;
    end
  end

  // half step acts at once, without an alignment
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      half_r <= 1'b0;
    end else begin
      half_r <= cfg.group_half_step;
    end
  end

  assign grp_clk  = clk_r;
  assign grp_half = half_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_go;
    align_start && take_part && !powerdown;
  endsequence

  a_force_low_five: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_go |-> ##5 !clk_r)
    else $error("group not forced low five cycles after one-shot start");

  a_release_d5: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_go and cfg.group_digital_delay == 8'h05
      |-> ##13 $rose(clk_r))
    else $error("group did not rise 5+5 cycles after one-shot end");

  a_release_d14: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_go and cfg.group_digital_delay == 8'h0e
      |-> ##5 (!clk_r)[*8] ##10 $rose(clk_r))
    else $error("group did not rise 5+14 cycles after one-shot end");

  a_exempt_free: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    align_start && cfg.group_align_exempt && !seq_act_r |=> !seq_act_r)
    else $error("exempt group entered the alignment sequence");

  a_half_now: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $changed(cfg.group_half_step) |=> grp_half == $past(cfg.group_half_step))
    else $error("half step change did not take effect at once");

endmodule

// ---- ddd_pkg.sv ----
// package: constants, field layouts and types of the dynamic delay aligner
package ddd_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_GRP = 3;
  localparam int AW      = 6;
  localparam int DW      = 32;
  localparam int CNT_W   = 9;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL   = 6'h00;
  localparam logic [AW-1:0] OFS_STATUS = 6'h04;
  localparam logic [AW-1:0] OFS_FINAL  = 6'h08;
  localparam logic [AW-1:0] OFS_GRP0   = 6'h10;
  localparam logic [AW-1:0] OFS_GRP1   = 6'h14;
  localparam logic [AW-1:0] OFS_GRP2   = 6'h18;

  // ---------------------------------------------------------------
  // control word: bit 0 upward in reverse of the declaration order
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       lock_loss_holdover_mask;  // bit 8
    logic       zero_delay_mode;          // bit 7
    logic       group2_powerdown;         // bit 6
    logic       loop_select_enable;       // bit 5
    logic [1:0] loop_select;              // bits 4:3
    logic       align_polarity_invert;    // bit 2
    logic       align_on_write;           // bit 1
    logic       align_qualify_enable;     // bit 0
  } ddd_ctrl_s;
  localparam int        CTRL_W   = $bits(ddd_ctrl_s);
  localparam ddd_ctrl_s CTRL_RST = 9'h000;

  // ---------------------------------------------------------------
  // per-group word (delay_config_word): divide 7:0, delay 15:8,
  // half step 16, exempt 17
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       group_align_exempt;
    logic       group_half_step;
    logic [7:0] group_digital_delay;
    logic [7:0] group_divide;
  } ddd_grp_s;
  localparam int       GRP_W   = $bits(ddd_grp_s);
  localparam ddd_grp_s GRP_RST = 18'h00502;

  // ---------------------------------------------------------------
  // timing in distribution-path cycles
  // ---------------------------------------------------------------
  localparam logic [1:0]       ONESHOT_LAG_CYC  = 2'h3;
  localparam logic [1:0]       ONESHOT_LEN_CYC  = 2'h3;
  localparam logic [CNT_W-1:0] FORCE_LOW_CYC    = 9'h005;
  localparam logic [CNT_W-1:0] RELEASE_BASE_CYC = 9'h005;

  // ---------------------------------------------------------------
  // alignment sequencer, gray along the usual path except ST_PULSE back to ST_IDLE (two bits)
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FALL1 = 3'h1,
    ST_FALL2 = 3'h3,
    ST_LEAD  = 3'h2,
    ST_PULSE = 3'h6
  } ddd_state_e;

endpackage

// ---- tb_top.sv ----
// testbench for the dynamic digital delay aligner
`timescale 1ns/10ps
module tb_top;
  import ddd_pkg::*;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic [AW-1:0]      address = 6'h00;
  logic               read = 1'b0;
  logic               write = 1'b0;
  logic [DW-1:0]      writedata = 32'h0;
  logic [DW-1:0]      readdata;
  logic               waitrequest;
  logic               align_pin;
  logic               pulse_req = 1'b0;
  logic               lock_indication = 1'b1;
  logic [NUM_GRP-1:0] group_clk;
  logic [NUM_GRP-1:0] group_half;
  logic               align_busy;
  logic               holdover_active;
  int                 error_cnt = 0;
  int                 total_checks = 0;
  logic [DW-1:0]      rd;

  always #10 clk_sys = ~clk_sys;

  ddd_align_top dut (.clk_sys(clk_sys), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .align_pin(align_pin), .lock_indication(lock_indication),
    .group_clk(group_clk), .group_half(group_half),
    .align_busy(align_busy), .holdover_active(holdover_active));

  ddd_host_pin host (.clk_sys(clk_sys), .nrst(nrst),
    .pulse_req(pulse_req), .align_pin(align_pin));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_word(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %b got %b", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // avalon master: hold until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(logic w, logic [AW-1:0] a, logic [DW-1:0] d);
    int i;
    @(posedge clk_sys);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      chk_bit("bus timeout", 1'b0, 1'b1);
      finish_test();
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  // wait for align_busy to reach a level within a bound
  task automatic wait_busy(logic lvl, int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_sys);
      if (align_busy === lvl) break;
    end
    chk_bit("align_busy", lvl, align_busy);
    if (i == lim) finish_test();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, OFS_CTRL, 32'h0);
    chk_word("ctrl", 32'h0, rd);
    bus(1'b0, OFS_GRP1, 32'h0);
    chk_word("grp1", 32'h00000502, rd);
    bus(1'b0, 6'h3c, 32'h0);
    chk_word("unmapped", 32'h0, rd);
  endtask

  // write-launched alignment: group 1 low from t+5, rises at t+8+delay
  task automatic t_auto(logic [7:0] dly);
    int n;
    logic prev;
    bus(1'b1, OFS_GRP1, {16'h0, dly, 8'h04});
    #1;
    prev = group_clk[0];
    for (n = 1; n <= 12 + dly; n++) begin
      @(posedge clk_sys);
      #1;
      chk_bit("exempt toggles", !prev, group_clk[0]);
      prev = group_clk[0];
      if (n >= 9 && n < 12 + dly)
        chk_bit("grp1 forced low", 1'b0, group_clk[1]);
    end
    chk_bit("grp1 rise", 1'b1, group_clk[1]);
    wait_busy(1'b0, 40);
  endtask

  task automatic t_manual();
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_GRP1, 32'h00010704);
    repeat (3) @(posedge clk_sys);
    chk_bit("half step", 1'b1, group_half[1]);
    chk_bit("no auto", 1'b0, align_busy);
    pulse_req <= 1'b1;
    @(posedge clk_sys);
    pulse_req <= 1'b0;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 60);
    bus(1'b1, OFS_CTRL, 32'h4);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 60);
    bus(1'b1, OFS_FINAL, 32'h0);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 60);
  endtask

  // qualified by group 2 through select code 2
  task automatic t_qual();
    bus(1'b1, OFS_CTRL, 32'h31);
    bus(1'b1, OFS_GRP2, 32'h00030502);
    bus(1'b1, OFS_FINAL, 32'h0);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 80);
    bus(1'b0, OFS_GRP2, 32'h0);
    chk_word("qual grp kept", 32'h00030502, rd);
  endtask

  task automatic t_hold();
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_GRP2, 32'h00000502);
    lock_indication <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h90);
    repeat (6) @(posedge clk_sys);
    chk_bit("holdover", 1'b1, holdover_active);
    bus(1'b1, OFS_CTRL, 32'h190);
    repeat (6) @(posedge clk_sys);
    chk_bit("holdover masked", 1'b0, holdover_active);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    bus(1'b1, OFS_GRP0, 32'h00020502);
    bus(1'b1, OFS_GRP2, 32'h00020502);
    bus(1'b1, OFS_CTRL, 32'h2);
    t_auto(8'h05);
    t_auto(8'h0e);
    t_manual();
    t_qual();
    t_hold();
    finish_test();
  end
endmodule
